// ### rtl/ascs_top.v
// Scan-select, compare-hit and measure-unit registers with AXI4-Lite access
// Function
// RULE_01 - Mode 11: hit flag sets on buffer write or match; else stays zero.
// RULE_02 - Other compare modes: hit flag sets only on a channel match.
// RULE_03 - Hit high word bits 9-0 channels 25-16; bits 15-10 read zero.
// RULE_04 - Scan includes channels whose select bit is one, skips zeros.
// RULE_05 - Scan high word: 30-28 in bits 14-12, 26-16 in 10-0.
// RULE_06 - Scan low word bits 15-0 map to channels 15-0.
// RULE_07 - Enable bit one connects the measure unit while that channel converts.
// RULE_08 - Measure high word: 30-28 in 14-12, 25-16 in 9-0, rest zero.
// RULE_09 - Reduced-pin build drops both hit-flag registers entirely.
// RULE_10 - Reduced-pin build drops measure enables for channels 23-16.
// RULE_11 - Conversion clock period is instruction cycle times divider plus one.
// RULE_12 - Compare mode: 00 below, 01 above, 10 inside, 11 outside window.
// RULE_13 - Write mode 10 compares only, stores nothing, still interrupts.
// RULE_14 - All implemented bits reset zero and are software read/write.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module ascs_top #(
  parameter RES_W = 12,
  parameter REDUCED_PIN = 0
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire conv_done_i,
  input wire [4:0] conv_chan_i,
  input wire [RES_W-1:0] conv_result_i,
  input wire [RES_W-1:0] buf_lo_i,
  input wire [RES_W-1:0] buf_hi_i,
  input wire seq_done_i,
  input wire osc_tick_i,
  output wire [30:0] scan_include_mask_o,
  output wire measure_unit_connect_o,
  output reg result_store_o,
  output reg [RES_W-1:0] result_data_o,
  output reg [4:0] result_chan_o,
  output reg tad_tick_o,
  output wire irq_o
);
`include "ascs_consts.vh"

  // Write-data mask for a register offset, used by the write path only; reads are not masked
  function [15:0] wmask;
    input [7:0] a;
    begin
      case (a)
        `ASCS_OFF_HIT_H: wmask = REDUCED_PIN ? 16'h0000 : `ASCS_HIT_H_MASK;
        `ASCS_OFF_HIT_L: wmask = REDUCED_PIN ? 16'h0000 : 16'hffff;
        `ASCS_OFF_SCAN_H: wmask = `ASCS_SCAN_H_MASK;
        `ASCS_OFF_SCAN_L: wmask = 16'hffff;
        `ASCS_OFF_MEAS_H: wmask = REDUCED_PIN ? `ASCS_MEAS_H_MASK_64 :
                                  `ASCS_MEAS_H_MASK;
        `ASCS_OFF_MEAS_L: wmask = 16'hffff;
        `ASCS_OFF_CTRL: wmask = `ASCS_CTRL_MASK;
        default: wmask = 16'h0000;
      endcase
    end
  endfunction

  function known;
    input [7:0] a;
    begin
      known = (a <= `ASCS_OFF_STATUS) && (a[1:0] == 2'h0);
    end
  endfunction

  reg [15:0] hit_h_q, hit_l_q, scan_h_q, scan_l_q, meas_h_q, meas_l_q;
  reg [15:0] ctrl_q;
  reg [`ASCS_IRQ_W-1:0] irq_stat_q, irq_mask_q;
  reg [7:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  reg [7:0] tad_cnt_q;
  reg [1:0] osc_cnt_q;
  reg cyc_tick_q;

  wire [1:0] cm = ctrl_q[`ASCS_CM_LSB +: 2];
  wire [1:0] wm = ctrl_q[`ASCS_WM_LSB +: 2];
  wire [7:0] divider = ctrl_q[`ASCS_DIV_LSB +: 8];

  // Write address and data may arrive in either order
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  wire aw_ok = aw_held_q || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_held_q || (s_axi_wvalid && s_axi_wready);
  wire [7:0] wa = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_held_q ? wstrb_q : s_axi_wstrb;
  wire wr_go = aw_ok && w_ok && !s_axi_bvalid;
  wire [15:0] byte_en = {{8{ws[1]}}, {8{ws[0]}}};
  wire [15:0] wr_bits = wd[15:0] & byte_en & wmask(wa);

  // Channel match and hit events
  wire match;
  ascs_match #(
    .RES_W(RES_W)
  ) u_match (
    .compare_mode_field_i(cm),
    .result_i(conv_result_i),
    .buf_lo_i(buf_lo_i),
    .buf_hi_i(buf_hi_i),
    .match_o(match)
  );

  wire [31:0] scan_all = {scan_h_q, scan_l_q};
  wire [31:0] meas_all = {meas_h_q, meas_l_q};
  wire chan_in = scan_all[conv_chan_i]; // see RULE_04
  wire stored = conv_done_i && chan_in &&
                (wm != `ASCS_WM_COMPARE_ONLY); // see RULE_13
  wire hit_ev = conv_done_i && chan_in &&
                (match || ((cm == `ASCS_CM_OUTSIDE) && stored));
  // see RULE_01 see RULE_02
  wire [31:0] hit_set = hit_ev ? (32'h1 << conv_chan_i) : 32'h0;

  assign scan_include_mask_o = {scan_h_q[14:12], 1'b0, scan_h_q[10:0],
                                scan_l_q}; // see RULE_05 see RULE_06
  assign measure_unit_connect_o = conv_done_i ? 1'b0 :
                                  meas_all[conv_chan_i]; // see RULE_07
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Hit flags: set wins over a software write
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hit_h_q <= `ASCS_RESET_16;
      hit_l_q <= `ASCS_RESET_16;
    end else if (REDUCED_PIN == 0) begin // see RULE_09
      if (wr_go && wa == `ASCS_OFF_HIT_H)
        hit_h_q <= ((hit_h_q & ~(byte_en & `ASCS_HIT_H_MASK)) | wr_bits |
                   hit_set[31:16]) & `ASCS_HIT_H_MASK; // see RULE_03
      else
        hit_h_q <= (hit_h_q | hit_set[31:16]) & `ASCS_HIT_H_MASK;
      if (wr_go && wa == `ASCS_OFF_HIT_L)
        hit_l_q <= (hit_l_q & ~byte_en) | wr_bits | hit_set[15:0];
      else
        hit_l_q <= hit_l_q | hit_set[15:0];
    end
  end

  // Plain read/write registers
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin // see RULE_14
      scan_h_q <= `ASCS_RESET_16;
      scan_l_q <= `ASCS_RESET_16;
      meas_h_q <= `ASCS_RESET_16;
      meas_l_q <= `ASCS_RESET_16;
      ctrl_q <= `ASCS_RESET_16;
    end else if (wr_go) begin
      case (wa)
        `ASCS_OFF_SCAN_H: scan_h_q <= (scan_h_q & ~byte_en) | wr_bits;
        `ASCS_OFF_SCAN_L: scan_l_q <= (scan_l_q & ~byte_en) | wr_bits;
        `ASCS_OFF_MEAS_H: meas_h_q <= (meas_h_q & ~byte_en) |
                                      wr_bits; // see RULE_08 see RULE_10
        `ASCS_OFF_MEAS_L: meas_l_q <= (meas_l_q & ~byte_en) | wr_bits;
        `ASCS_OFF_CTRL: ctrl_q <= (ctrl_q & ~byte_en) | wr_bits;
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Interrupt status: write one to clear, event set wins
  wire [`ASCS_IRQ_W-1:0] irq_ev = {conv_done_i && chan_in, seq_done_i,
                                    hit_ev};
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_q <= {`ASCS_IRQ_W{1'b0}};
      irq_mask_q <= {`ASCS_IRQ_W{1'b0}};
    end else begin
      if (wr_go && wa == `ASCS_OFF_IRQ_STAT && ws[0])
        irq_stat_q <= (irq_stat_q & ~wd[`ASCS_IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_q <= irq_stat_q | irq_ev; // see RULE_13
      if (wr_go && wa == `ASCS_OFF_IRQ_MASK && ws[0])
        irq_mask_q <= wd[`ASCS_IRQ_W-1:0];
    end
  end

  // Result store strobe, suppressed in compare-only mode
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_store_o <= 1'b0;
      result_data_o <= {RES_W{1'b0}};
      result_chan_o <= 5'h00;
    end else begin
      result_store_o <= stored; // see RULE_13
      if (stored) begin
        result_data_o <= conv_result_i;
        result_chan_o <= conv_chan_i;
      end
    end
  end

  // Conversion clock: instruction cycle is two oscillator ticks
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      osc_cnt_q <= 2'h0;
      cyc_tick_q <= 1'b0;
      tad_cnt_q <= 8'h00;
      tad_tick_o <= 1'b0;
    end else begin
      cyc_tick_q <= 1'b0;
      tad_tick_o <= 1'b0;
      if (osc_tick_i) begin
        if (osc_cnt_q == `ASCS_INSTR_OSC_PERIODS - 1) begin // see RULE_11
          osc_cnt_q <= 2'h0;
          cyc_tick_q <= 1'b1;
        end else begin
          osc_cnt_q <= osc_cnt_q + 2'h1;
        end
      end
      if (cyc_tick_q) begin
        if (tad_cnt_q >= divider) begin // see RULE_11
          tad_cnt_q <= 8'h00;
          tad_tick_o <= 1'b1;
        end else begin
          tad_cnt_q <= tad_cnt_q + 8'h01;
        end
      end
    end
  end

  // Write channel bookkeeping and response
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ASCS_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(wa) ? `ASCS_RESP_OKAY : `ASCS_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
      end
    end
  end

  // Read path
  assign s_axi_arready = !s_axi_rvalid;
  reg [15:0] rd_val;
  always @* begin
    case (s_axi_araddr)
      `ASCS_OFF_HIT_H: rd_val = hit_h_q;
      `ASCS_OFF_HIT_L: rd_val = hit_l_q;
      `ASCS_OFF_SCAN_H: rd_val = scan_h_q;
      `ASCS_OFF_SCAN_L: rd_val = scan_l_q;
      `ASCS_OFF_MEAS_H: rd_val = meas_h_q;
      `ASCS_OFF_MEAS_L: rd_val = meas_l_q;
      `ASCS_OFF_CTRL: rd_val = ctrl_q;
      `ASCS_OFF_IRQ_STAT: rd_val = {13'h0, irq_stat_q};
      `ASCS_OFF_IRQ_MASK: rd_val = {13'h0, irq_mask_q};
      `ASCS_OFF_STATUS: rd_val = {8'h00, tad_cnt_q};
      default: rd_val = 16'h0000;
    endcase
  end

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `ASCS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= known(s_axi_araddr) ? `ASCS_RESP_OKAY :
                     `ASCS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ascs_top

// ### rtl/ascs_consts.vh
// Offsets, field layouts, reset values and timing for the scan/compare block
`ifndef ASCS_CONSTS_VH
`define ASCS_CONSTS_VH
`define ASCS_OFF_HIT_H 8'h00
`define ASCS_OFF_HIT_L 8'h04
`define ASCS_OFF_SCAN_H 8'h08
`define ASCS_OFF_SCAN_L 8'h0c
`define ASCS_OFF_MEAS_H 8'h10
`define ASCS_OFF_MEAS_L 8'h14
`define ASCS_OFF_CTRL 8'h18
`define ASCS_OFF_IRQ_STAT 8'h1c
`define ASCS_OFF_IRQ_MASK 8'h20
`define ASCS_OFF_STATUS 8'h24
`define ASCS_HIT_H_MASK 16'h03ff
`define ASCS_SCAN_H_MASK 16'h77ff
`define ASCS_MEAS_H_MASK 16'h73ff
`define ASCS_MEAS_H_MASK_64 16'h7300
`define ASCS_RESET_16 16'h0000
`define ASCS_CM_LSB 0
`define ASCS_WM_LSB 2
`define ASCS_DIV_LSB 8
`define ASCS_CTRL_MASK 16'hff0f
`define ASCS_CM_LESS 2'h0
`define ASCS_CM_GREATER 2'h1
`define ASCS_CM_INSIDE 2'h2
`define ASCS_CM_OUTSIDE 2'h3
`define ASCS_WM_COMPARE_ONLY 2'h2
`define ASCS_IRQ_HIT 0
`define ASCS_IRQ_SEQ 1
`define ASCS_IRQ_DONE 2
`define ASCS_IRQ_W 3
`define ASCS_INSTR_OSC_PERIODS 2
`define ASCS_RESP_OKAY 2'h0
`define ASCS_RESP_SLVERR 2'h2
`endif

// ### rtl/ascs_match.v
// Per-channel compare test against a buffer value or buffer pair
`timescale 1ns/1ps
module ascs_match #(
  parameter RES_W = 12
) (
  input wire [1:0] compare_mode_field_i,
  input wire [RES_W-1:0] result_i,
  input wire [RES_W-1:0] buf_lo_i,
  input wire [RES_W-1:0] buf_hi_i,
  output reg match_o
);
`include "ascs_consts.vh"
  always @* begin
    case (compare_mode_field_i) // see RULE_12
      `ASCS_CM_LESS: match_o = (result_i < buf_lo_i);
      `ASCS_CM_GREATER: match_o = (result_i > buf_lo_i);
      `ASCS_CM_INSIDE: match_o = (result_i >= buf_lo_i) &&
                                 (result_i <= buf_hi_i);
      `ASCS_CM_OUTSIDE: match_o = (result_i < buf_lo_i) ||
                                  (result_i > buf_hi_i);
      default: match_o = 1'b0;
    endcase
  end
endmodule // ascs_match

// ### tb/ascs_top_assertions.sv
// Assertion checker for the scan/compare register block
`timescale 1ns/1ps
module ascs_chk (
  input wire sys_clk_i,
  input wire rst_i,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire conv_done_i,
  input wire [4:0] conv_chan_i,
  input wire [30:0] scan_include_mask_o,
  input wire measure_unit_connect_o,
  input wire result_store_o,
  input wire [4:0] result_chan_o
);
  wire incl = conv_done_i && scan_include_mask_o[conv_chan_i];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("bvalid dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while rvalid");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready while bvalid");
  a_store_cause: assert property (result_store_o |-> $past(incl) &&
    result_chan_o == $past(conv_chan_i)) else $error("bad store");
  a_skip_chan: assert property (conv_done_i && !incl |=>
    !result_store_o) else $error("skipped channel stored");
  a_scan_gap: assert property (!scan_include_mask_o[27])
    else $error("scan bit 27 set");
  a_meas_idle: assert property (measure_unit_connect_o |->
    !conv_done_i) else $error("measure unit connected after done");
  c_store: cover property (result_store_o);
  c_meas: cover property (measure_unit_connect_o);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // ascs_chk
bind ascs_top ascs_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .conv_done_i(conv_done_i), .conv_chan_i(conv_chan_i),
  .scan_include_mask_o(scan_include_mask_o),
  .measure_unit_connect_o(measure_unit_connect_o),
  .result_store_o(result_store_o), .result_chan_o(result_chan_o));

// ### tb/test_adc_scan_compare_select.sv
// Self-checking bench for the scan/compare register block
`timescale 1ns/1ps
`include "ascs_consts.vh"
module test_adc_scan_compare_select;
  localparam [95:0] MSK = {16'hffff, 16'h73ff, 16'hffff, 16'h77ff,
    16'hffff, 16'h03ff};
  localparam [95:0] MSK_RP = {16'hffff, 16'h7300, 16'hffff, 16'h77ff,
    16'h0000, 16'h0000};
  reg clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  reg cd = 0, sd = 0, ot = 0;
  reg [7:0] awa = 0, ara = 0, a;
  reg [31:0] wd = 0, got, got2;
  reg [4:0] cc = 0;
  reg [11:0] cr = 0, bl = 12'h064, bh = 12'h0c8;
  reg [1:0] rsp;
  wire awr, wrd, bv, arr, rv, mc, rs, tt, irq;
  wire [1:0] br, rr;
  wire [31:0] rd, rd2;
  wire [11:0] rdt;
  wire [4:0] rch;
  wire [30:0] sm;
  integer failures = 0, checks_done = 0, cyc = 0, i, n;
  always #25 clk = ~clk;
  ascs_top dut (.sys_clk_i(clk), .rst_i(rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'h3), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .conv_done_i(cd), .conv_chan_i(cc),
    .conv_result_i(cr), .buf_lo_i(bl), .buf_hi_i(bh), .seq_done_i(sd),
    .osc_tick_i(ot), .scan_include_mask_o(sm),
    .measure_unit_connect_o(mc), .result_store_o(rs), .result_data_o(rdt),
    .result_chan_o(rch), .tad_tick_o(tt), .irq_o(irq));
  // Reduced-pin build on the same stimulus
  ascs_top #(.REDUCED_PIN(1)) dut_rp (.sys_clk_i(clk), .rst_i(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(),
    .s_axi_rdata(rd2), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready(rry), .conv_done_i(cd), .conv_chan_i(cc),
    .conv_result_i(cr), .buf_lo_i(bl), .buf_hi_i(bh), .seq_done_i(sd),
    .osc_tick_i(ot), .scan_include_mask_o(), .measure_unit_connect_o(),
    .result_store_o(), .result_data_o(), .result_chan_o(), .tad_tick_o(),
    .irq_o());
  task end_of_test;
    begin
      $display("Checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task axw(input [7:0] ad, input [15:0] d);
    begin
      @(posedge clk);
      awa <= ad;
      wd <= {16'h0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wrd) wv <= 1'b0;
      end while (!bv);
      bry <= 1'b0;
      rsp = br;
    end
  endtask
  task axr(input [7:0] ad);
    begin
      @(posedge clk);
      ara <= ad;
      arv <= 1'b1;
      rry <= 1'b1;
      do begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
      end while (!rv);
      rry <= 1'b0;
      got = rd;
      got2 = rd2;
      rsp = rr;
    end
  endtask
  task cv(input [4:0] c, input [11:0] r, input st);
    begin
      @(posedge clk);
      cc <= c;
      cr <= r;
      cd <= 1'b1;
      @(posedge clk);
      cd <= 1'b0;
      #1 chk({31'h0, rs}, {31'h0, st});
      if (st) chk({15'h0, rch, rdt}, {15'h0, c, r});
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (a = 0; a < 8'h18; a = a + 4) begin
      axr(a);
      chk(got, 0);
      axw(a, 16'hffff);
      chk({30'h0, rsp}, 0);
      axr(a);
      chk(got, {16'h0, MSK[a * 4 +: 16]});
      chk(got2, {16'h0, MSK_RP[a * 4 +: 16]});
    end
    chk({1'b0, sm}, 32'h77ffffff);
    axr(8'h80);
    chk({30'h0, rsp}, {30'h0, `ASCS_RESP_SLVERR});
    chk(got, 0);
    axw(8'h80, 16'hffff);
    chk({30'h0, rsp}, {30'h0, `ASCS_RESP_SLVERR});
    axw(8'h04, 16'h0000);
    axw(8'h20, 16'h0001);
    for (i = 0; i < 4; i = i + 1) begin
      axw(8'h18, i[15:0]);
      cv({i[3:0], 1'b0}, 12'h032, 1'b1);
      cv({i[3:0], 1'b1}, 12'h096, 1'b1);
    end
    axr(8'h04);
    chk(got, 32'h000000e9);
    chk(got2, 0);
    #1 chk({31'h0, irq}, 1);
    axw(8'h1c, 16'h0001);
    axw(8'h20, 16'h0000);
    cv(5'd8, 12'h032, 1'b1);
    #1 chk({31'h0, irq}, 0);
    axw(8'h20, 16'h0001);
    #1 chk({31'h0, irq}, 1);
    axw(8'h1c, 16'h0007);
    #1 chk({31'h0, irq}, 0);
    @(posedge clk);
    sd <= 1'b1;
    @(posedge clk);
    sd <= 1'b0;
    axr(8'h1c);
    chk(got, 32'h2);
    axw(8'h0c, 16'hfdff);
    axw(8'h18, 16'h0000);
    cv(5'd9, 12'h032, 1'b0);
    #1 chk({31'h0, irq}, 0);
    axw(8'h18, 16'h0008);
    cv(5'd10, 12'h032, 1'b0);
    #1 chk({31'h0, irq}, 1);
    axr(8'h04);
    chk({30'h0, got[10:9]}, 32'h2);
    axw(8'h14, 16'h0002);
    cc <= 5'd1;
    #1 chk({31'h0, mc}, 1);
    cc <= 5'd2;
    #1 chk({31'h0, mc}, 0);
    axw(8'h18, 16'h0200);
    ot <= 1'b1;
    @(posedge clk);
    while (!tt) @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (!tt);
    chk(n, 6);
    end_of_test;
  end
endmodule // test_adc_scan_compare_select
